// ===== rtl/clm_cfg.svh
`ifndef CLM_CFG_SVH
`define CLM_CFG_SVH
`define CLM_NUM_CH 10
`define CLM_DATA_W 10
`define CLM_FRAC_W 14
`define CLM_ALARM_W 24
`define CLM_RESULT_RST 10'h200
`define CLM_UPPER_RST 10'h3FF
`define CLM_LOWER_RST 10'h000
`define CLM_CFG_RST 8'h00
`define CLM_ALARM_RST 24'h000000
`define CLM_FAULT_MSB 7
`define CLM_FAULT_LSB 4
`define CLM_AVG_MSB 3
`define CLM_AVG_LSB 0
`define CLM_AVG_MAX 4'hB
`define CLM_CODE_NONE 2'b00
`define CLM_CODE_LOW 2'b01
`define CLM_CODE_HIGH 2'b10
`define CLM_SETUP_DRIVE 4
`define CLM_SETUP_POL 3
`define CLM_FIRST_AIN 4'h2
`endif

// ===== rtl/clm_pkg.sv
package clm_pkg;
   typedef enum logic [2:0] {
      CLM_SEL_RESULT,
      CLM_SEL_UPPER,
      CLM_SEL_LOWER,
      CLM_SEL_CONFIG,
      CLM_SEL_ALARM
   } clm_sel_t;

   typedef struct packed {
      logic wr;
      logic rd;
      clm_sel_t sel;
      logic [3:0] chan;
      logic [9:0] wdata;
   } clm_acc_t;

   typedef struct packed {
      logic valid;
      logic [3:0] chan;
      logic [9:0] data;
   } clm_conv_t;

   typedef struct packed {
      logic all;
      logic one;
      logic [3:0] chan;
   } clm_clear_t;
endpackage

// ===== rtl/clm_monitor.sv
`timescale 1ns/1ps
`include "clm_cfg.svh"
module clm_monitor
   import clm_pkg::*;
#(
   parameter int FRAC_W = `CLM_FRAC_W
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire clm_acc_t acc_i,
   input wire clm_conv_t conv_i,
   input wire clm_clear_t clear_i,
   input wire logic soft_reset_i,
   input wire logic [7:0] setup_i,
   input wire logic [9:0] chan_signed_i,
   input wire logic [3:0] pair_diff_i,
   output logic [23:0] rdata_o,
   output logic rvalid_o,
   output logic [23:0] alarm_o,
   output logic int_o,
   output logic int_oe_n_o
);
   localparam int NCH = `CLM_NUM_CH;
   localparam int DW = `CLM_DATA_W;
   localparam int ACC_W = DW + FRAC_W;

   initial begin
      if (FRAC_W < 11 || FRAC_W > 20) begin
         $error("FRAC_W must allow an 11-bit shift");
      end
   end

   // Odd member of a differential pair borrows the even channel's registers
   function automatic logic [3:0] eff_ch(input logic [3:0] c,
                                        input logic [3:0] diff);
      logic [3:0] p;
      p = c - 4'h3;
      if (c > `CLM_FIRST_AIN && c[0] && diff[p[2:1]]) begin
         return c - 4'h1;
      end
      return c;
   endfunction

   function automatic logic lim_gt(input logic [DW-1:0] a,
                                   input logic [DW-1:0] b,
                                   input logic sgn);
      if (sgn) begin
         return $signed(a) > $signed(b);
      end
      return a > b;
   endfunction

   // Offset-binary trick lets one unsigned datapath average signed data
   function automatic logic [ACC_W-1:0] filt(input logic [ACC_W-1:0] acc,
                                             input logic [DW-1:0] smp,
                                             input logic [3:0] code,
                                             input logic sgn);
      logic [ACC_W-1:0] flip;
      logic [ACC_W-1:0] a;
      logic [ACC_W-1:0] s;
      logic signed [ACC_W:0] d;
      logic [3:0] k;
      flip = {sgn, {(ACC_W-1){1'b0}}};
      a = acc ^ flip;
      s = {smp, {FRAC_W{1'b0}}} ^ flip;
      d = $signed({1'b0, s}) - $signed({1'b0, a});
      k = (code > `CLM_AVG_MAX) ? `CLM_AVG_MAX : code;
      a = a + ACC_W'(d >>> k);
      return a ^ flip;
   endfunction

   function automatic logic [1:0] pair_of(input logic [23:0] v,
                                          input logic [3:0] c);
      logic [4:0] lo;
      lo = 5'd22 - {c, 1'b0};
      return v[lo +: 2];
   endfunction

   logic rst_meta_ff;
   logic rst_n_ff;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   logic [ACC_W-1:0] acc_ff [NCH];
   logic [DW-1:0] upper_ff [NCH];
   logic [DW-1:0] lower_ff [NCH];
   logic [7:0] cfg_ff [NCH];
   logic [4:0] cnt_ff [NCH];
   logic [1:0] side_ff [NCH];
   logic [23:0] alarm_ff;
   logic s1_valid_ff;
   logic [3:0] s1_ch_ff;
   logic rvalid_ff;
   logic [23:0] rdata_ff;
   logic int_ff;
   logic int_oe_n_ff;

   logic [3:0] conv_ch;
   logic conv_ok;
   logic host_wr_ok;
   assign conv_ch = eff_ch(conv_i.chan, pair_diff_i);
   assign conv_ok = conv_i.valid && conv_i.chan < 4'(NCH);
   assign host_wr_ok = acc_i.wr && acc_i.chan < 4'(NCH);

   // Result storage: filter updates, host write seeds the filter
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         for (int i = 0; i < NCH; i++) begin
            acc_ff[i] <= {`CLM_RESULT_RST, {FRAC_W{1'b0}}};
         end
      end else if (soft_reset_i) begin
         for (int i = 0; i < NCH; i++) begin
            acc_ff[i] <= {`CLM_RESULT_RST, {FRAC_W{1'b0}}};
         end
      end else begin
         if (conv_ok) begin
            acc_ff[conv_ch] <= filt(acc_ff[conv_ch], conv_i.data,
               cfg_ff[conv_ch][`CLM_AVG_MSB:`CLM_AVG_LSB],
               chan_signed_i[conv_ch]);
         end
         // Host write wins a same-cycle collision with a conversion
         if (host_wr_ok && acc_i.sel == CLM_SEL_RESULT) begin
            acc_ff[acc_i.chan] <= {acc_i.wdata, {FRAC_W{1'b0}}};
         end
      end
   end

   // Limits and per-channel configuration
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         for (int i = 0; i < NCH; i++) begin
            upper_ff[i] <= `CLM_UPPER_RST;
            lower_ff[i] <= `CLM_LOWER_RST;
            cfg_ff[i] <= `CLM_CFG_RST;
         end
      end else if (soft_reset_i) begin
         for (int i = 0; i < NCH; i++) begin
            upper_ff[i] <= `CLM_UPPER_RST;
            lower_ff[i] <= `CLM_LOWER_RST;
            cfg_ff[i] <= `CLM_CFG_RST;
         end
      end else if (host_wr_ok) begin
         unique case (acc_i.sel)
            CLM_SEL_UPPER: upper_ff[acc_i.chan] <= acc_i.wdata;
            CLM_SEL_LOWER: lower_ff[acc_i.chan] <= acc_i.wdata;
            CLM_SEL_CONFIG: cfg_ff[acc_i.chan] <= acc_i.wdata[7:0];
            default: ;
         endcase
      end
   end

   // Compare one cycle after the filter, on the stored result
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         s1_valid_ff <= 1'b0;
         s1_ch_ff <= 4'h0;
      end else begin
         s1_valid_ff <= conv_ok && !soft_reset_i;
         s1_ch_ff <= conv_ch;
      end
   end

   logic [DW-1:0] s1_res;
   logic above;
   logic below;
   logic [1:0] s1_side;
   logic [4:0] nxt_cnt;
   logic [4:0] need;
   logic s1_set;
   logic cfg_wr;
   always_comb begin
      s1_res = acc_ff[s1_ch_ff][ACC_W-1:FRAC_W];
      above = lim_gt(s1_res, upper_ff[s1_ch_ff],
                     chan_signed_i[s1_ch_ff]);
      below = lim_gt(lower_ff[s1_ch_ff], s1_res,
                     chan_signed_i[s1_ch_ff]);
      s1_side = above ? `CLM_CODE_HIGH :
                below ? `CLM_CODE_LOW : `CLM_CODE_NONE;
      if (s1_side == `CLM_CODE_NONE) begin
         nxt_cnt = 5'h00;
      end else if (s1_side != side_ff[s1_ch_ff]) begin
         nxt_cnt = 5'h01;
      end else if (cnt_ff[s1_ch_ff] == 5'h1F) begin
         nxt_cnt = 5'h1F;
      end else begin
         nxt_cnt = cnt_ff[s1_ch_ff] + 5'h01;
      end
      need = {1'b0, cfg_ff[s1_ch_ff][`CLM_FAULT_MSB:`CLM_FAULT_LSB]}
             + 5'h01;
      s1_set = s1_valid_ff && s1_side != `CLM_CODE_NONE
               && nxt_cnt >= need;
   end
   assign cfg_wr = host_wr_ok && acc_i.sel == CLM_SEL_CONFIG;

   // Fault counters; a fresh configuration restarts the count
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         for (int i = 0; i < NCH; i++) begin
            cnt_ff[i] <= 5'h00;
            side_ff[i] <= `CLM_CODE_NONE;
         end
      end else if (soft_reset_i) begin
         for (int i = 0; i < NCH; i++) begin
            cnt_ff[i] <= 5'h00;
            side_ff[i] <= `CLM_CODE_NONE;
         end
      end else begin
         if (s1_valid_ff) begin
            cnt_ff[s1_ch_ff] <= nxt_cnt;
            side_ff[s1_ch_ff] <= s1_side;
         end
         if (cfg_wr) begin
            cnt_ff[acc_i.chan] <= 5'h00;
            side_ff[acc_i.chan] <= `CLM_CODE_NONE;
         end
      end
   end

   // Alarm word: clears first, a same-cycle alarm overrides them
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         alarm_ff <= `CLM_ALARM_RST;
      end else if (soft_reset_i) begin
         alarm_ff <= `CLM_ALARM_RST;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (clear_i.all ||
                (clear_i.one && clear_i.chan == 4'(i)) ||
                (cfg_wr && acc_i.chan == 4'(i))) begin
               alarm_ff[23-2*i -: 2] <= `CLM_CODE_NONE;
            end
            if (s1_set && s1_ch_ff == 4'(i)) begin
               alarm_ff[23-2*i -: 2] <= s1_side;
            end
         end
         alarm_ff[3:0] <= 4'h0;
      end
   end

   // Register reads; the alarm word is never written
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 24'h000000;
      end else begin
         rvalid_ff <= acc_i.rd;
         if (acc_i.rd) begin
            rdata_ff <= 24'h000000;
            if (acc_i.sel == CLM_SEL_ALARM) begin
               rdata_ff <= alarm_ff;
            end else if (acc_i.chan < 4'(NCH)) begin
               unique case (acc_i.sel)
                  CLM_SEL_RESULT:
                     rdata_ff[DW-1:0] <= acc_ff[acc_i.chan][ACC_W-1:FRAC_W];
                  CLM_SEL_UPPER: rdata_ff[DW-1:0] <= upper_ff[acc_i.chan];
                  CLM_SEL_LOWER: rdata_ff[DW-1:0] <= lower_ff[acc_i.chan];
                  CLM_SEL_CONFIG: rdata_ff[7:0] <= cfg_ff[acc_i.chan];
                  default: ;
               endcase
            end
         end
      end
   end

   // Interrupt pin; open-drain leaves the line to the pull when idle
   logic any_alarm;
   assign any_alarm = |alarm_ff;
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         int_ff <= 1'b1;
         int_oe_n_ff <= 1'b1;
      end else begin
         int_ff <= any_alarm ~^ setup_i[`CLM_SETUP_POL];
         int_oe_n_ff <= !setup_i[`CLM_SETUP_DRIVE] && !any_alarm;
      end
   end

   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign alarm_o = alarm_ff;
   assign int_o = int_ff;
   assign int_oe_n_o = int_oe_n_ff;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_ff);

   a_int_level: assert property (
      ##1 int_o == ($past(any_alarm) ~^ $past(setup_i[`CLM_SETUP_POL])))
      else $error("interrupt level does not follow alarm word");
   a_od_release: assert property (
      (!setup_i[`CLM_SETUP_DRIVE] && !any_alarm) |=> int_oe_n_o)
      else $error("open-drain pin driven while idle");
   a_pp_drive: assert property (
      setup_i[`CLM_SETUP_DRIVE] |=> !int_oe_n_o)
      else $error("push-pull pin not driven");
   a_reserved_bits: assert property (
      ##1 alarm_ff[3:0] == 4'h0)
      else $error("reserved alarm bits set");
   a_alarm_code: assert property (
      (s1_set && !soft_reset_i)
      |=> pair_of(alarm_ff, $past(s1_ch_ff)) == $past(s1_side)
          && $past(s1_side) != 2'b11)
      else $error("alarm pair not loaded with fault side");
   a_alarm_hold: assert property (
      (!s1_set && !clear_i.all && !clear_i.one && !cfg_wr && !soft_reset_i)
      |=> alarm_ff == $past(alarm_ff))
      else $error("alarm word changed without a set or clear");
   a_count_gate: assert property (
      (s1_valid_ff && s1_side != `CLM_CODE_NONE && nxt_cnt < need
       && !clear_i.all && !clear_i.one && !cfg_wr && !soft_reset_i
       && pair_of(alarm_ff, s1_ch_ff) == `CLM_CODE_NONE)
      |=> pair_of(alarm_ff, $past(s1_ch_ff)) == `CLM_CODE_NONE)
      else $error("alarm raised before fault count reached");
   a_window_clear: assert property (
      (s1_valid_ff && s1_side == `CLM_CODE_NONE)
      |=> cnt_ff[$past(s1_ch_ff)] == 5'h00)
      else $error("fault counter kept inside window");
   a_side_flip: assert property (
      (s1_valid_ff && s1_side != `CLM_CODE_NONE
       && s1_side != side_ff[s1_ch_ff] && !soft_reset_i)
      |=> cnt_ff[$past(s1_ch_ff)] <= 5'h01)
      else $error("fault counter not restarted on side change");
   a_no_average: assert property (
      (conv_ok && cfg_ff[conv_ch][3:0] == 4'h0 && !soft_reset_i
       && !(host_wr_ok && acc_i.sel == CLM_SEL_RESULT))
      |=> acc_ff[$past(conv_ch)][ACC_W-1:FRAC_W] == $past(conv_i.data))
      else $error("unfiltered result not stored");
   a_clear_all: assert property (
      (clear_i.all && !s1_set) |=> alarm_ff == `CLM_ALARM_RST)
      else $error("clear-all left alarms set");
   a_soft_reset: assert property (
      soft_reset_i |=> acc_ff[0][ACC_W-1:FRAC_W] == `CLM_RESULT_RST
                       && alarm_ff == `CLM_ALARM_RST)
      else $error("reset command did not restore defaults");
endmodule

// ===== verification/clm_host_model.sv
`timescale 1ns/1ps
module clm_host_model
   import clm_pkg::*;
(
   input wire logic clk_i,
   input wire logic [23:0] rdata_i,
   input wire logic rvalid_i,
   output clm_acc_t acc_o,
   output clm_clear_t clear_o
);
   initial begin
      acc_o = '0;
      clear_o = '0;
   end

   // Strobes last one cycle; a call always starts on a fresh falling edge
   task automatic write_reg(input clm_sel_t sel, input logic [3:0] ch,
      input logic [9:0] d);
      @(negedge clk_i);
      acc_o <= '{wr: 1'b1, rd: 1'b0, sel: sel, chan: ch, wdata: d};
      @(negedge clk_i);
      acc_o.wr <= 1'b0;
   endtask

   task automatic read_reg(input clm_sel_t sel, input logic [3:0] ch,
      output logic [23:0] q);
      int n;
      @(negedge clk_i);
      acc_o <= '{wr: 1'b0, rd: 1'b1, sel: sel, chan: ch, wdata: 10'h000};
      @(negedge clk_i);
      acc_o.rd <= 1'b0;
      n = 0;
      while (rvalid_i !== 1'b1 && n < 4) begin
         @(negedge clk_i);
         n++;
      end
      q = (rvalid_i === 1'b1) ? rdata_i : 'x;
   endtask

   task automatic clear_alarms(input logic one, input logic [3:0] ch);
      @(negedge clk_i);
      clear_o <= '{all: !one, one: one, chan: ch};
      @(negedge clk_i);
      clear_o <= '0;
   endtask

   // Source is read before anything else, then every alarm is dropped
   task automatic service(output logic [23:0] src);
      read_reg(CLM_SEL_ALARM, 4'h0, src);
      clear_alarms(1'b0, 4'h0);
   endtask
endmodule

// ===== verification/channel_limit_monitor_bench.sv
`timescale 1ns/1ps
module channel_limit_monitor_bench
   import clm_pkg::*;
;
   logic clk;
   logic arst_n;
   logic soft_reset;
   logic [7:0] setup;
   logic [9:0] chan_signed;
   logic [3:0] pair_diff;
   clm_conv_t conv;
   clm_acc_t acc;
   clm_clear_t clr;
   logic [23:0] rdata;
   logic [23:0] alarm;
   logic [23:0] q;
   logic [23:0] exp_avg;
   logic rvalid;
   logic int_raw;
   logic int_oe_n;
   wire int_pin;
   int err_total;
   int checks_done;
   int cyc;

   // Pull-up on the wired-OR line
   assign int_pin = int_oe_n ? 1'b1 : int_raw;

   clm_monitor u_clm_monitor (
      .clk_i(clk),
      .arst_n_i(arst_n),
      .acc_i(acc),
      .conv_i(conv),
      .clear_i(clr),
      .soft_reset_i(soft_reset),
      .setup_i(setup),
      .chan_signed_i(chan_signed),
      .pair_diff_i(pair_diff),
      .rdata_o(rdata),
      .rvalid_o(rvalid),
      .alarm_o(alarm),
      .int_o(int_raw),
      .int_oe_n_o(int_oe_n)
   );

   clm_host_model u_clm_host_model (
      .clk_i(clk),
      .rdata_i(rdata),
      .rvalid_i(rvalid),
      .acc_o(acc),
      .clear_o(clr)
   );

   always #4 clk = ~clk;

   task automatic print_verdict();
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [23:0] exp,
      input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input string what, input clm_sel_t sel,
      input logic [3:0] ch, input logic [23:0] exp);
      logic [23:0] v;
      u_clm_host_model.read_reg(sel, ch, v);
      chk(what, exp, v);
   endtask

   task automatic wr(input clm_sel_t sel, input logic [3:0] ch,
      input logic [9:0] d);
      u_clm_host_model.write_reg(sel, ch, d);
   endtask

   // Waits out the alarm and pin latency after the sample is taken
   task automatic convert(input logic [3:0] ch, input logic [9:0] d);
      @(negedge clk);
      conv <= '{valid: 1'b1, chan: ch, data: d};
      @(negedge clk);
      conv.valid <= 1'b0;
      repeat (3) @(negedge clk);
   endtask

   function automatic logic [23:0] pair(input int ch, input logic [1:0] c);
      return 24'(c) << (22 - 2 * ch);
   endfunction

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      soft_reset = 1'b0;
      setup = 8'h00;
      chan_signed = 10'h000;
      pair_diff = 4'h0;
      conv = '0;
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int c = 0; c < 10; c++) begin
         rd_chk("result", CLM_SEL_RESULT, 4'(c), 24'h000200);
         rd_chk("upper", CLM_SEL_UPPER, 4'(c), 24'h0003FF);
         rd_chk("lower", CLM_SEL_LOWER, 4'(c), 24'h000000);
         rd_chk("config", CLM_SEL_CONFIG, 4'(c), 24'h000000);
      end
      rd_chk("alarm", CLM_SEL_ALARM, 4'h0, 24'h000000);
      chk("pin idle", 24'h000001, {23'h0, int_pin});
      wr(CLM_SEL_RESULT, 4'h2, 10'h155);
      rd_chk("result wr", CLM_SEL_RESULT, 4'h2, 24'h000155);
      wr(CLM_SEL_ALARM, 4'h0, 10'h3FF);
      rd_chk("alarm wr", CLM_SEL_ALARM, 4'h0, 24'h000000);
      rd_chk("bad chan", CLM_SEL_UPPER, 4'hC, 24'h000000);
      wr(CLM_SEL_UPPER, 4'h6, 10'h100);
      convert(4'h6, 10'h100);
      chk("at upper", 24'h0, alarm);
      convert(4'h6, 10'h101);
      chk("above upper", pair(6, 2'b10), alarm);
      chk("pin active", 24'h0, {23'h0, int_pin});
      u_clm_host_model.service(q);
      chk("alarm src", pair(6, 2'b10), q);
      repeat (2) @(negedge clk);
      chk("after clear", 24'h0, alarm);
      chk("pin released", 24'h1, {23'h0, int_pin});
      wr(CLM_SEL_CONFIG, 4'h4, 10'h020);
      wr(CLM_SEL_LOWER, 4'h4, 10'h050);
      wr(CLM_SEL_UPPER, 4'h4, 10'h300);
      convert(4'h4, 10'h040);
      convert(4'h4, 10'h040);
      convert(4'h4, 10'h060);
      convert(4'h4, 10'h040);
      convert(4'h4, 10'h040);
      chk("window reset", 24'h0, alarm);
      convert(4'h4, 10'h040);
      chk("third low", pair(4, 2'b01), alarm);
      wr(CLM_SEL_CONFIG, 4'h4, 10'h020);
      @(negedge clk);
      chk("config clear", 24'h0, alarm);
      convert(4'h4, 10'h040);
      convert(4'h4, 10'h040);
      convert(4'h4, 10'h310);
      convert(4'h4, 10'h310);
      chk("side swap", 24'h0, alarm);
      convert(4'h4, 10'h310);
      chk("third high", pair(4, 2'b10), alarm);
      u_clm_host_model.clear_alarms(1'b1, 4'h4);
      @(negedge clk);
      chk("clear one", 24'h0, alarm);
      chan_signed = 10'h001;
      wr(CLM_SEL_UPPER, 4'h0, 10'h1FF);
      convert(4'h0, 10'h1FF);
      chk("signed top", 24'h0, alarm);
      convert(4'h0, 10'h3F0);
      chk("signed low", pair(0, 2'b01), alarm);
      setup = 8'h18;
      repeat (2) @(negedge clk);
      chk("push high", 24'h1, {22'h0, int_oe_n, int_raw});
      u_clm_host_model.clear_alarms(1'b0, 4'h0);
      repeat (2) @(negedge clk);
      chk("push idle", 24'h0, {22'h0, int_oe_n, int_raw});
      setup = 8'h10;
      repeat (2) @(negedge clk);
      chk("push low idle", 24'h1, {22'h0, int_oe_n, int_raw});
      // Reserved codes are expected to behave as the deepest average
      for (int k = 0; k < 16; k++) begin
         wr(CLM_SEL_CONFIG, 4'h5, 10'(k));
         wr(CLM_SEL_RESULT, 4'h5, 10'h000);
         convert(4'h5, 10'h3FF);
         exp_avg = 24'(10'h3FF >> ((k > 11) ? 11 : k));
         rd_chk("average", CLM_SEL_RESULT, 4'h5, exp_avg);
      end
      pair_diff = 4'h1;
      wr(CLM_SEL_UPPER, 4'h2, 10'h100);
      convert(4'h3, 10'h200);
      chk("odd of pair", pair(2, 2'b10), alarm);
      @(negedge clk);
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      @(negedge clk);
      chk("soft alarm", 24'h0, alarm);
      rd_chk("soft result", CLM_SEL_RESULT, 4'h5, 24'h000200);
      rd_chk("soft upper", CLM_SEL_UPPER, 4'h2, 24'h0003FF);
      rd_chk("soft config", CLM_SEL_CONFIG, 4'h4, 24'h000000);
      wr(CLM_SEL_UPPER, 4'h0, 10'h1FF);
      wr(CLM_SEL_LOWER, 4'h0, 10'h200);
      convert(4'h0, 10'h010);
      chk("signed floor", 24'h0, alarm);
      print_verdict();
   end
endmodule
